// [common/fbirq_pkg.sv]
// Package: register map, field layout and constants of the interrupt request nodes
package fbirq_pkg;
    localparam int NodeCount = 10;
    localparam int EthNodeCount = 9;
    localparam logic [11:0] FastBusNodeOffset = 12'h000;
    localparam logic [11:0] NodeStride = 12'h004;
    localparam logic [11:0] IrqStatusOffset = 12'h040;
    localparam logic [11:0] IrqMaskOffset = 12'h044;
    localparam logic [11:0] AckOffset = 12'h048;
    localparam int PrioLsb = 0;
    localparam int PrioWidth = 8;
    localparam int TypeLsb = 10;
    localparam int TypeWidth = 2;
    localparam int EnableBit = 12;
    localparam int FlagBit = 13;
    localparam int ClearBit = 14;
    localparam int SetBit = 15;
    localparam logic [31:0] NodeReset = 32'h0000_0000;
    localparam logic [9:0] StatusReset = 10'h000;
    localparam logic [9:0] MaskReset = 10'h000;
    localparam int SlowClockMhz = 48;
    localparam int FastClockMhz = 96;
endpackage : fbirq_pkg

// [hdl/fbirq_nodes.sv]
// Service request nodes for the fast bus controller and nine Ethernet requests
module fbirq_nodes
    import fbirq_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request inputs: bit 0 fast bus controller, bits 9:1 Ethernet
    input wire logic fastBusRequest,
    input wire logic [EthNodeCount-1:0] ethRequest,
    // Service side: taken pulses clear flags of forwarded (enabled) requests only
    input wire logic [NodeCount-1:0] serviceTaken,
    output logic [NodeCount-1:0] nodeRequest,
    output logic [NodeCount*PrioWidth-1:0] nodePriority,
    output logic [NodeCount*TypeWidth-1:0] nodeServiceType,
    // Interrupt
    output logic irq
);
    logic [NodeCount-1:0] requestIn;
    logic [NodeCount-1:0] detected;
    logic [PrioWidth-1:0] prioReg [NodeCount];
    logic [PrioWidth-1:0] prioNext [NodeCount];
    logic [TypeWidth-1:0] typeReg [NodeCount];
    logic [TypeWidth-1:0] typeNext [NodeCount];
    logic [NodeCount-1:0] enableReg;
    logic [NodeCount-1:0] enableNext;
    logic [NodeCount-1:0] flagReg;
    logic [NodeCount-1:0] flagNext;
    logic [NodeCount-1:0] statusReg;
    logic [NodeCount-1:0] statusNext;
    logic [NodeCount-1:0] maskReg;
    logic [NodeCount-1:0] maskNext;
    logic [31:0] rdataReg;
    logic [31:0] rdataNext;
    logic errReg;
    logic errNext;
    logic setup;
    logic writeTaken;
    logic [NodeCount-1:0] nodeHit;
    logic nodeAny;

    assign requestIn = {ethRequest, fastBusRequest};

    // Each line samples in the slow clock domain; sources keep the minimum widths
    genvar g;
    generate
        for (g = 0; g < NodeCount; g++) begin : gDetect
            fbirq_pulse_detect uDetect (
                .clock(clock),
                .resetn(resetn),
                .request(requestIn[g]),
                .detected(detected[g])
            );
        end
    endgenerate

    // Registers latch on the setup cycle, so the access phase always completes in one cycle
    assign setup = psel && !penable;
    assign writeTaken = setup && pwrite;

    always_comb begin
        nodeAny = 1'b0;
        for (int i = 0; i < NodeCount; i++) begin
            nodeHit[i] = (paddr == FastBusNodeOffset + NodeStride * 12'(i));
            nodeAny = nodeAny | nodeHit[i];
        end
    end

    always_comb begin
        enableNext = enableReg;
        flagNext = flagReg;
        statusNext = statusReg;
        maskNext = maskReg;
        for (int i = 0; i < NodeCount; i++) begin
            prioNext[i] = prioReg[i];
            typeNext[i] = typeReg[i];
            if (writeTaken && nodeHit[i]) begin
                prioNext[i] = pwdata[PrioLsb +: PrioWidth];
                typeNext[i] = pwdata[TypeLsb +: TypeWidth];
                enableNext[i] = pwdata[EnableBit];
                if (pwdata[ClearBit] && !pwdata[SetBit]) begin
                    flagNext[i] = 1'b0;
                end
                if (pwdata[SetBit] && !pwdata[ClearBit]) begin
                    flagNext[i] = 1'b1;
                end
            end
            if (serviceTaken[i] && nodeRequest[i]) begin
                flagNext[i] = 1'b0;
            end
            // Hardware set wins over every clear in the same cycle
            if (detected[i]) begin
                flagNext[i] = 1'b1;
                statusNext[i] = 1'b1;
            end else if (writeTaken && paddr == IrqStatusOffset && pwdata[i]) begin
                statusNext[i] = 1'b0;
            end
        end
        if (writeTaken && paddr == IrqMaskOffset) begin
            maskNext = pwdata[NodeCount-1:0];
        end
    end

    always_comb begin
        rdataNext = 32'h0000_0000;
        errNext = 1'b0;
        if (setup && !pwrite) begin
            for (int i = 0; i < NodeCount; i++) begin
                if (nodeHit[i]) begin
                    rdataNext[PrioLsb +: PrioWidth] = prioReg[i];
                    rdataNext[TypeLsb +: TypeWidth] = typeReg[i];
                    rdataNext[EnableBit] = enableReg[i];
                    rdataNext[FlagBit] = flagReg[i];
                end
            end
            if (paddr == IrqStatusOffset) begin
                rdataNext[NodeCount-1:0] = statusReg;
            end
            if (paddr == IrqMaskOffset) begin
                rdataNext[NodeCount-1:0] = maskReg;
            end
        end
        if (setup && !nodeAny && paddr != IrqStatusOffset && paddr != IrqMaskOffset) begin
            errNext = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NodeCount; i++) begin
                prioReg[i] <= NodeReset[PrioLsb +: PrioWidth];
                typeReg[i] <= NodeReset[TypeLsb +: TypeWidth];
            end
            enableReg <= '0;
            flagReg <= '0;
            statusReg <= StatusReset;
            maskReg <= MaskReset;
            rdataReg <= 32'h0000_0000;
            errReg <= 1'b0;
        end else begin
            prioReg <= prioNext;
            typeReg <= typeNext;
            enableReg <= enableNext;
            flagReg <= flagNext;
            statusReg <= statusNext;
            maskReg <= maskNext;
            rdataReg <= rdataNext;
            errReg <= errNext;
        end
    end

    assign pready = 1'b1;
    assign prdata = rdataReg;
    assign pslverr = errReg && psel && penable;
    // Flag is forwarded only while its node is enabled
    assign nodeRequest = flagReg & enableReg;
    assign irq = |(statusReg & maskReg);

    always_comb begin
        for (int i = 0; i < NodeCount; i++) begin
            nodePriority[i*PrioWidth +: PrioWidth] = prioReg[i];
            nodeServiceType[i*TypeWidth +: TypeWidth] = typeReg[i];
        end
    end

    a_detect_sets_flag: assert property (@(posedge clock) disable iff (!resetn)
        detected[0] |=> flagReg[0] && statusReg[0])
        else $error("detected request did not set flag");
    a_eth_detect_flag: assert property (@(posedge clock) disable iff (!resetn)
        detected[NodeCount-1] |=> flagReg[NodeCount-1])
        else $error("ethernet request did not set flag");
    a_service_clears: assert property (@(posedge clock) disable iff (!resetn)
        serviceTaken[0] && nodeRequest[0] && !detected[0] && !writeTaken
        |=> !flagReg[0])
        else $error("serviced flag not cleared");
    a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
        $rose(penable) && psel && !pwrite && nodeAny |->
        prdata[31:16] == 16'h0000 && prdata[9:8] == 2'h0 && prdata[15:14] == 2'h0)
        else $error("reserved node bits not zero");
    a_prio_written: assert property (@(posedge clock) disable iff (!resetn)
        writeTaken && nodeHit[0] |=> prioReg[0] == $past(pwdata[PrioLsb +: PrioWidth]))
        else $error("priority not stored");
    a_type_written: assert property (@(posedge clock) disable iff (!resetn)
        writeTaken && nodeHit[1] |=> typeReg[1] == $past(pwdata[TypeLsb +: TypeWidth]))
        else $error("service type not stored");
    a_set_bit_flag: assert property (@(posedge clock) disable iff (!resetn)
        writeTaken && nodeHit[2] && pwdata[SetBit] && !pwdata[ClearBit]
        |=> flagReg[2])
        else $error("set bit did not set flag");
    a_enable_gates: assert property (@(posedge clock) disable iff (!resetn)
        !enableReg[3] |-> !nodeRequest[3])
        else $error("disabled node forwarded request");
    a_read_layout: assert property (@(posedge clock) disable iff (!resetn)
        setup && !pwrite && nodeHit[4] ##1 penable |->
        prdata[FlagBit] == $past(flagReg[4]) && prdata[EnableBit] == $past(enableReg[4]))
        else $error("node read layout wrong");
    a_request_to_flag: assert property (@(posedge clock) disable iff (!resetn)
        !requestIn[5] ##1 requestIn[5] |=> flagReg[5])
        else $error("held request not captured");

    // Status is sticky until software writes a one; the interrupt follows it as a level
    a_status_set: assert property (@(posedge clock) disable iff (!resetn)
        detected[4] |=> statusReg[4])
        else $error("detected request did not set status");
    a_status_w1c: assert property (@(posedge clock) disable iff (!resetn)
        writeTaken && paddr == IrqStatusOffset && pwdata[0] && !detected[0] |=> !statusReg[0])
        else $error("status bit not cleared by write");
    a_status_sticky: assert property (@(posedge clock) disable iff (!resetn)
        statusReg[1] && !(writeTaken && paddr == IrqStatusOffset && pwdata[1]) |=> statusReg[1])
        else $error("status bit dropped without a write");
    a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
        statusReg[2] && maskReg[2] |-> irq)
        else $error("unmasked status did not raise irq");
    a_irq_quiet: assert property (@(posedge clock) disable iff (!resetn)
        !(|(statusReg & maskReg)) |-> !irq)
        else $error("irq high with nothing unmasked");
    a_mask_written: assert property (@(posedge clock) disable iff (!resetn)
        writeTaken && paddr == IrqMaskOffset |=> maskReg == $past(pwdata[NodeCount-1:0]))
        else $error("mask not stored");

    // Software flag control; the hardware set still has the last word
    a_clear_bit_flag: assert property (@(posedge clock) disable iff (!resetn)
        writeTaken && nodeHit[6] && pwdata[ClearBit] && !pwdata[SetBit] && !detected[6]
        |=> !flagReg[6])
        else $error("clear bit did not clear flag");
    a_both_bits_hold: assert property (@(posedge clock) disable iff (!resetn)
        writeTaken && nodeHit[7] && pwdata[ClearBit] && pwdata[SetBit] && !detected[7]
        && !(serviceTaken[7] && nodeRequest[7])
        |=> flagReg[7] == $past(flagReg[7]))
        else $error("set and clear together changed flag");
    a_enable_written: assert property (@(posedge clock) disable iff (!resetn)
        writeTaken && nodeHit[8] |=> enableReg[8] == $past(pwdata[EnableBit]))
        else $error("enable not stored");
    a_flag_no_spurious: assert property (@(posedge clock) disable iff (!resetn)
        !flagReg[0] && !detected[0] && !(writeTaken && nodeHit[0] && pwdata[SetBit])
        |=> !flagReg[0])
        else $error("flag set with no cause");

    // Forwarding to the arbiter
    a_forward_flag: assert property (@(posedge clock) disable iff (!resetn)
        flagReg[9] && enableReg[9] |-> nodeRequest[9])
        else $error("enabled flag not forwarded");
    a_forward_off: assert property (@(posedge clock) disable iff (!resetn)
        !flagReg[5] |-> !nodeRequest[5])
        else $error("request forwarded without flag");

    // Bus answers: zero wait states, error only off the map
    a_ready_high: assert property (@(posedge clock) disable iff (!resetn)
        psel && penable |-> pready)
        else $error("access phase not ready");
    a_unmapped_err: assert property (@(posedge clock) disable iff (!resetn)
        $rose(penable) && psel && !nodeAny && paddr != IrqStatusOffset
        && paddr != IrqMaskOffset |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (@(posedge clock) disable iff (!resetn)
        psel && penable && nodeAny |-> !pslverr)
        else $error("node access refused");
    a_write_read_zero: assert property (@(posedge clock) disable iff (!resetn)
        $rose(penable) && psel && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data not zero during write");

    // Field outputs move only when their node is written
    a_prio_stable: assert property (@(posedge clock) disable iff (!resetn)
        !(writeTaken && nodeHit[0]) |=> $stable(nodePriority[PrioWidth-1:0]))
        else $error("priority changed without write");
    a_type_stable: assert property (@(posedge clock) disable iff (!resetn)
        !(writeTaken && nodeHit[1]) |=> $stable(nodeServiceType[2*TypeWidth-1:TypeWidth]))
        else $error("service type changed without write");

    // Detection is per line: one line never marks a neighbour
    a_rise_detected: assert property (@(posedge clock) disable iff (!resetn)
        !requestIn[0] ##1 requestIn[0] |-> detected[0])
        else $error("rising request not detected");
    a_idle_quiet: assert property (@(posedge clock) disable iff (!resetn)
        !requestIn[3] |-> !detected[3])
        else $error("detector fired on idle line");
    a_eth_separate: assert property (@(posedge clock) disable iff (!resetn)
        detected[2] && !detected[1] && !flagReg[1] && !(writeTaken && nodeHit[1])
        |=> !flagReg[1])
        else $error("request leaked to another node");

    c_request_flagged: cover property (@(posedge clock) disable iff (!resetn)
        detected[0] ##1 flagReg[0]);
    c_eth_serviced: cover property (@(posedge clock) disable iff (!resetn)
        nodeRequest[1] ##[1:20] serviceTaken[1]);
    c_irq_raised: cover property (@(posedge clock) disable iff (!resetn) $rose(irq));
    c_set_clear_race: cover property (@(posedge clock) disable iff (!resetn)
        detected[2] && writeTaken && nodeHit[2] && pwdata[ClearBit]);
    c_unmapped_err: cover property (@(posedge clock) disable iff (!resetn) pslverr);
endmodule : fbirq_nodes

// [hdl/fbirq_pulse_detect.sv]
// Rising-edge request detector for one request line
module fbirq_pulse_detect (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Request line and detected edge
    input wire logic request,
    output logic detected
);
    logic lastReg;
    logic lastNext;

    always_comb begin
        lastNext = request;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lastReg <= 1'b0;
        end else begin
            lastReg <= lastNext;
        end
    end

    // One pulse per low-to-high level seen on a slow clock edge
    assign detected = request && !lastReg;

    a_edge_once: assert property (@(posedge clock) disable iff (!resetn)
        detected |=> !detected)
        else $error("detector fired on two edges in a row");
endmodule : fbirq_pulse_detect

// [test/fbirq_request_source.sv]
// Request source model for the bus controller and Ethernet request lines
module fbirq_request_source (
    // Clock
    input wire logic clock,
    // One-cycle start strobes, bit 0 bus controller
    input wire logic [9:0] fire,
    // Request levels
    output logic fastBusRequest,
    output logic [8:0] ethRequest
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold [10];
    int gap [10];
    logic [9:0] level = 10'h000;
    assign fastBusRequest = level[0];
    assign ethRequest = level[9:1];
    // A start during a hold or gap is dropped, as a real source would merge it
    always @(posedge clock) begin
        for (int i = 0; i < 10; i++) begin
            if (hold[i] > 0) begin
                hold[i]--;
                if (hold[i] == 0) gap[i] = 2;
            end else if (gap[i] > 0) begin
                gap[i]--;
            end else if (fire[i]) begin
                hold[i] = 2;
            end
            level[i] <= (hold[i] > 0);
        end
    end
endmodule // fbirq_request_source

// [test/test_fast_bus_and_ethernet_irq_nodes.sv]
// Self-checking bench for the interrupt request nodes
module test_fast_bus_and_ethernet_irq_nodes;
    import fbirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d, r;
    logic fastBusRequest, e;
    logic [8:0] ethRequest;
    logic [9:0] fire = 10'h000, serviceTaken = 10'h000, nodeRequest, flg, sts, msk, nrq;
    logic [79:0] nodePriority;
    logic [19:0] nodeServiceType;
    logic [31:0] fld [10];
    int failures = 0, comparisons = 0, seed = 25124;
    fbirq_nodes i_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fastBusRequest(fastBusRequest), .ethRequest(ethRequest),
        .serviceTaken(serviceTaken), .nodeRequest(nodeRequest), .nodePriority(nodePriority),
        .nodeServiceType(nodeServiceType), .irq(irq));
    fbirq_request_source i_src (.clock(clock), .fire(fire), .fastBusRequest(fastBusRequest),
        .ethRequest(ethRequest));
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next setup never overwrites this release
        @(posedge clock);
    endtask
    function automatic logic [31:0] nodeExp(input int i);
        return (fld[i] & 32'h0000_1cff) | ({31'h0, flg[i]} << FlagBit);
    endfunction
    // Write a node and track what software can see of it
    task automatic wrNode(input int i, input logic [31:0] wd);
        apb(1'b1, 12'(4 * i), wd);
        fld[i] = wd;
        if (wd[SetBit] && !wd[ClearBit]) flg[i] = 1'b1;
        if (wd[ClearBit] && !wd[SetBit]) flg[i] = 1'b0;
    endtask
    task automatic readAll();
        for (int i = 0; i < NodeCount; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check("node", nodeExp(i), r);
        end
        apb(1'b0, IrqStatusOffset, 32'h0);
        check("status", {22'h0, sts}, r);
        check("irq", {31'h0, |(sts & msk)}, {31'h0, irq});
        for (int i = 0; i < NodeCount; i++) nrq[i] = flg[i] & fld[i][EnableBit];
        check("nodeRequest", {22'h0, nrq}, {22'h0, nodeRequest});
    endtask
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(20 * 20000);
        failures++;
        conclude();
    end
    initial begin
        flg = 10'h000;
        sts = 10'h000;
        msk = 10'h000;
        for (int i = 0; i < NodeCount; i++) fld[i] = NodeReset;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        readAll();
        for (int i = 0; i < NodeCount; i++) begin
            wrNode(i, $random(seed));
            apb(1'b0, 12'(4 * i), 32'h0);
            check("node rw", nodeExp(i), r);
            check("prio", {24'h0, fld[i][7:0]}, {24'h0, nodePriority[8 * i +: 8]});
            check("type", {30'h0, fld[i][11:10]}, {30'h0, nodeServiceType[2 * i +: 2]});
            wrNode(i, ($random(seed) & 32'h0000_0fff) | 32'h0000_5000);
        end
        msk = 10'($random(seed));
        apb(1'b1, IrqMaskOffset, {22'h0, msk});
        fire <= 10'h3ff;
        @(posedge clock);
        fire <= 10'h000;
        repeat (4) @(posedge clock);
        flg = 10'h3ff;
        sts = 10'h3ff;
        check("raised", 32'h3ff, {22'h0, nodeRequest});
        readAll();
        serviceTaken <= 10'h3ff;
        @(posedge clock);
        serviceTaken <= 10'h000;
        @(posedge clock);
        flg = 10'h000;
        check("taken", 32'h0, {22'h0, nodeRequest});
        apb(1'b1, IrqStatusOffset, 32'h3ff);
        sts = 10'h000;
        readAll();
        wrNode(3, 32'h0000_9000);
        wrNode(3, 32'h0000_d000);
        check("set", 32'h8, {22'h0, nodeRequest});
        apb(1'b0, AckOffset, 32'h0);
        check("unmapped", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, r);
        conclude();
    end
endmodule // test_fast_bus_and_ethernet_irq_nodes
